// ### core/tsgc_regs.vh
// register map, field positions, reset values and timing counts of the slider group control
`ifndef TSGC_REGS_VH
`define TSGC_REGS_VH
`define TSGC_ADDR_SPEED      8'h3e
`define TSGC_ADDR_RECAL      8'h3f
`define TSGC_ADDR_CFG2       8'h40
`define TSGC_ADDR_GRP_EN     8'h41
`define TSGC_RST_SPEED       8'hc5
`define TSGC_RST_RECAL       8'h00
`define TSGC_RST_CFG2        8'h00
`define TSGC_RST_GRP_EN      8'h7f
`define TSGC_CFG2_WMASK      8'hbf
`define TSGC_GRP_EN_WMASK    8'h7f
// speed configuration fields
`define TSGC_SPD_ACC_EN      7
`define TSGC_SPD_MAXI_HI     6
`define TSGC_SPD_MAXI_LO     4
`define TSGC_SPD_STIME_HI    3
`define TSGC_SPD_STIME_LO    2
`define TSGC_SPD_SCALE_HI    1
`define TSGC_SPD_SCALE_LO    0
// feature configuration two fields
`define TSGC_CFG_LINK_INV    7
`define TSGC_CFG_LED11_SEL   5
`define TSGC_CFG_POL_DECPL   4
`define TSGC_CFG_RF_ONLY     3
`define TSGC_CFG_RF_FDIS     2
`define TSGC_CFG_SEP_MODE    1
`define TSGC_CFG_REL_SUPP    0
// timing: one polling cycle lasts 35 ms
`define TSGC_POLL_MS         35
`define TSGC_SPEED_WIN_MS    100
`define TSGC_SPEED_WIN_CYC   3
`define TSGC_STIME0_MS       350
`define TSGC_STIME1_MS       560
`define TSGC_STIME2_MS       770
`define TSGC_STIME3_MS       980
`define TSGC_LED11_FIX_HZ    2000
`define TSGC_CLK_HZ          40000000
`endif

// ### core/tsgc_speed_est.v
// slide speed estimator: counts new grouped touches in a window of polling cycles
`timescale 1ns/10ps
`include "tsgc_regs.vh"
module tsgc_speed_est
(
  // clock and reset
  input  wire       core_clk_i,
  input  wire       rst_i,
  // polling cycle strobe and touch vector
  input  wire       poll_tick_i,
  input  wire [6:0] new_touch_i,
  // speed count of the last full window
  output reg  [2:0] speed_cnt_o,
  output reg        win_done_o
);
  reg [2:0] acc_r;
  reg [1:0] cyc_r;
  reg [2:0] add_w;
  integer   k;

  // population count of new touches
  always @*
  begin
    add_w = 3'h0;
    for (k = 0; k < 7; k = k + 1)
      add_w = add_w + {2'h0, new_touch_i[k]};
  end

  // window of three polling cycles, about 100 ms; sum saturates at 7
  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      acc_r       <= 3'h0;
      cyc_r       <= 2'h0;
      speed_cnt_o <= 3'h0;
      win_done_o  <= 1'b0;
    end
    else
    begin
      win_done_o <= 1'b0;
      if (poll_tick_i)
      begin
        if (cyc_r == `TSGC_SPEED_WIN_CYC - 1)
        begin
          speed_cnt_o <= ({1'b0, acc_r} + {1'b0, add_w} > 4'h7) ? 3'h7 : acc_r + add_w;
          win_done_o  <= 1'b1;
          acc_r       <= 3'h0;
          cyc_r       <= 2'h0;
        end
        else
        begin
          acc_r <= ({1'b0, acc_r} + {1'b0, add_w} > 4'h7) ? 3'h7 : acc_r + add_w;
          cyc_r <= cyc_r + 2'h1;
        end
      end
    end
  end
endmodule // tsgc_speed_est

// ### core/tsgc_recal_ctl.v
// forced recalibration request bits with self clear on completion
`timescale 1ns/10ps
`include "tsgc_regs.vh"
module tsgc_recal_ctl
(
  // clock and reset
  input  wire       core_clk_i,
  input  wire       rst_i,
  // register write side
  input  wire       wr_i,
  input  wire [7:0] wdata_i,
  // recalibration engine handshake
  input  wire [7:0] recal_done_i,
  output wire [7:0] recal_req_o,
  output reg  [7:0] recal_r
);
  // set by software wins over done pulse in the same cycle
  always @(posedge core_clk_i)
  begin
    if (rst_i)
      recal_r <= `TSGC_RST_RECAL;
    else
      recal_r <= (recal_r & ~recal_done_i) | (wr_i ? wdata_i : 8'h00);
  end

  // bit 7 asks for the whole group, bits 6..0 for sensors 7..1
  assign recal_req_o = recal_r;
endmodule // tsgc_recal_ctl

// ### core/tsgc_top.v
// slider group control: registers, repeat scaling, extra slide interrupts, grouped mode steering
// Overview of operation
// - extra slide interrupts only when slide time within selected 350/560/770/980 ms limit
// - slide speed is count of grouped sensors touched in about 100 ms
// - repeat interval picked from speed count and two-bit scale setting
// - base rate 105 ms or less makes scale 11 use 140/105/70 ms
// - repeat interval counted in polling cycles between interrupts
// - recalibration request bits self clear once routine finishes
// - recal bit 7 is whole group, bits 6..0 sensors 7..1
// - link invert bit 0 sets min equal max, 1 inverts touch signal
// - led eleven base frequency fixed near 2000 Hz or from its register
// - mirror controls follow polarity writes unless decouple bit set
// - rf-only bit hides low-frequency noise from status, blocking stays
// - rf filter zeroes delta on rf noise unless disabled
// - grouped mode zero treats seven sensors as one slider with group threshold
// - separate mode gives per sensor interrupts and status, no slide
// - separate mode middle sensors use button queue and repeat; max duration all
// - end sensors use tap and hold, repeat while held, no release interrupt
// - sensor eight sets down, sensor fourteen sets up, plus tap and hold
// - release suppress bit drops release interrupts, keeps press and repeat
// - grouped sensor polled only while enabled, reset enables all seven
// - accelerated extra interrupts only when enabled, capped at max setting
`timescale 1ns/10ps
`include "tsgc_regs.vh"
module tsgc_top
(
  // clock and reset
  input  wire       core_clk_i,
  input  wire       rst_i,
  // register port from the serial interface
  input  wire       reg_wr_i,
  input  wire       reg_rd_i,
  input  wire [7:0] reg_addr_i,
  input  wire [7:0] reg_wdata_i,
  output reg  [7:0] reg_rdata_o,
  // measurement engine
  input  wire       poll_tick_i,
  input  wire [6:0] grp_touch_i,
  input  wire [6:0] grp_release_i,
  input  wire [6:0] grp_held_i,
  input  wire       slide_done_i,
  input  wire [5:0] slide_cycles_i,
  input  wire [2:0] slide_base_rate_i,
  input  wire [7:0] recal_done_i,
  output wire [7:0] recal_req_o,
  output wire [6:0] grp_sample_en_o,
  // noise handling
  input  wire [13:0] rf_noise_i,
  input  wire [13:0] lf_noise_i,
  output reg  [13:0] noise_flag_o,
  output reg  [13:0] delta_zero_o,
  // led side controls
  input  wire       polarity_wr_i,
  input  wire [10:0] polarity_val_i,
  output reg  [10:0] mirror_o,
  output wire       link_invert_o,
  output wire       link_min_eq_max_o,
  output wire       led_eleven_freq_select_freq_o,
  // slider and button events
  output reg        slider_int_o,
  output reg  [6:0] btn_status2_o,
  output reg        up_status_o,
  output reg        down_status_o,
  output reg        tap_status_o,
  output reg        hold_status_o,
  output wire       slider_mode_o,
  output wire [6:0] queue_repeat_sel_o
);
  localparam ST_IDLE  = 2'h0;
  localparam ST_EXTRA = 2'h1;
  localparam ST_RPT   = 2'h2;

  reg  [7:0] speed_cfg_r;
  reg  [7:0] cfg2_r;
  reg  [7:0] grp_en_r;
  reg  [1:0] state_r;
  reg  [2:0] extra_left_r;
  reg  [2:0] rpt_cnt_r;
  reg  [6:0] end_rpt_r;
  reg  [2:0] rpt_sel_r;
  wire [7:0] recal_r;
  wire [2:0] speed_cnt;
  wire       win_done;
  wire       sep_mode;
  wire [6:0] grp_touch_en;
  wire [6:0] grp_rel_en;
  wire [6:0] grp_held_en;
  wire       wr_recal;
  wire [5:0] stime_cyc;
  wire [2:0] extra_n;
  wire [2:0] max_int;
  wire [6:0] rpt_held;

  // slide time limit in polling cycles, rounded down
  function [5:0] stime_cycles;
    input [1:0] code;
    integer     lim;
    begin
      case (code)
        2'h0:    lim = `TSGC_STIME0_MS / `TSGC_POLL_MS;
        2'h1:    lim = `TSGC_STIME1_MS / `TSGC_POLL_MS;
        2'h2:    lim = `TSGC_STIME2_MS / `TSGC_POLL_MS;
        default: lim = `TSGC_STIME3_MS / `TSGC_POLL_MS;
      endcase
      // longest limit is 28 cycles, six bits hold it
      stime_cycles = lim[5:0];
    end
  endfunction

  // repeat interval in polling cycles from speed count and scale
  function [2:0] repeat_cycles;
    input [2:0] cnt;
    input [1:0] scale;
    input [2:0] base;
    reg   [2:0] steps;
    begin
      steps = 3'h1;
      if (cnt >= 3'h5)
        steps = 3'h1;
      else if (cnt == 3'h4)
        steps = (scale == 2'h3) ? 3'h2 : 3'h1;
      else if (cnt == 3'h3)
        steps = (scale == 2'h3) ? 3'h3 : ((scale == 2'h2) ? 3'h2 : 3'h1);
      else if (cnt == 3'h2)
        steps = {1'b0, scale} + 3'h1;
      else
        steps = base;
      // short base rate keeps the fixed 140/105/70 ms for scale 11
      if (base <= 3'h3 && scale == 2'h3 && cnt >= 3'h2 && cnt <= 3'h4)
        steps = 3'h6 - cnt;
      repeat_cycles = (steps == 3'h0) ? 3'h1 : steps;
    end
  endfunction

  assign sep_mode     = cfg2_r[`TSGC_CFG_SEP_MODE];
  assign wr_recal     = reg_wr_i && reg_addr_i == `TSGC_ADDR_RECAL;
  assign grp_touch_en = grp_touch_i & grp_en_r[6:0];
  assign grp_rel_en   = grp_release_i & grp_en_r[6:0];
  assign grp_held_en  = grp_held_i & grp_en_r[6:0];
  // separate mode: only the two end sensors repeat here, middle ones use button repeat
  assign rpt_held     = sep_mode ? end_rpt_r : grp_held_en;
  assign stime_cyc    = stime_cycles(speed_cfg_r[`TSGC_SPD_STIME_HI:`TSGC_SPD_STIME_LO]);
  assign max_int      = speed_cfg_r[`TSGC_SPD_MAXI_HI:`TSGC_SPD_MAXI_LO];
  // extra count by fraction of limit: full, half, quarter of the cap
  assign extra_n = ({slide_cycles_i, 1'b0} < stime_cyc) ? max_int :
                   ({slide_cycles_i, 2'h0} < {stime_cyc, 1'b0} + {1'b0, stime_cyc}) ? (max_int >> 1) :
                   (max_int >> 2);

  tsgc_speed_est u_speed
  (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .poll_tick_i (poll_tick_i),
    .new_touch_i (sep_mode ? 7'h00 : grp_touch_en),
    .speed_cnt_o (speed_cnt),
    .win_done_o  (win_done)
  );

  tsgc_recal_ctl u_recal
  (
    .core_clk_i   (core_clk_i),
    .rst_i        (rst_i),
    .wr_i         (wr_recal),
    .wdata_i      (reg_wdata_i),
    .recal_done_i (recal_done_i),
    .recal_req_o  (recal_req_o),
    .recal_r      (recal_r)
  );

  // register writes; updates to the enable register take effect at once
  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      speed_cfg_r <= `TSGC_RST_SPEED;
      cfg2_r      <= `TSGC_RST_CFG2;
      grp_en_r    <= `TSGC_RST_GRP_EN;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        `TSGC_ADDR_SPEED:  speed_cfg_r <= reg_wdata_i;
        `TSGC_ADDR_CFG2:   cfg2_r      <= reg_wdata_i & `TSGC_CFG2_WMASK;
        `TSGC_ADDR_GRP_EN: grp_en_r    <= reg_wdata_i & `TSGC_GRP_EN_WMASK;
        default:           ;
      endcase
    end
  end

  // read mux; unmapped offsets read zero
  always @(posedge core_clk_i)
  begin
    if (rst_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        `TSGC_ADDR_SPEED:  reg_rdata_o <= speed_cfg_r;
        `TSGC_ADDR_RECAL:  reg_rdata_o <= recal_r;
        `TSGC_ADDR_CFG2:   reg_rdata_o <= cfg2_r;
        `TSGC_ADDR_GRP_EN: reg_rdata_o <= grp_en_r;
        default:           reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // only enabled grouped sensors are polled; slider relies on all seven
  assign grp_sample_en_o    = grp_en_r[6:0];
  assign slider_mode_o      = ~sep_mode;
  assign queue_repeat_sel_o = sep_mode ? 7'h3e : 7'h00;
  assign link_invert_o      = cfg2_r[`TSGC_CFG_LINK_INV];
  assign link_min_eq_max_o  = ~cfg2_r[`TSGC_CFG_LINK_INV];
  assign led_eleven_freq_select_freq_o   = cfg2_r[`TSGC_CFG_LED11_SEL];

  // noise status and rf blocking per channel
  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      noise_flag_o <= 14'h0000;
      delta_zero_o <= 14'h0000;
    end
    else
    begin
      noise_flag_o <= cfg2_r[`TSGC_CFG_RF_ONLY] ? rf_noise_i : (rf_noise_i | lf_noise_i);
      delta_zero_o <= cfg2_r[`TSGC_CFG_RF_FDIS] ? 14'h0000 : rf_noise_i;
    end
  end

  // mirror follows polarity writes unless decoupled
  always @(posedge core_clk_i)
  begin
    if (rst_i)
      mirror_o <= 11'h000;
    else if (polarity_wr_i && !cfg2_r[`TSGC_CFG_POL_DECPL])
      mirror_o <= polarity_val_i;
  end

  // separate mode buttons: per sensor status, end sensors tap/hold with repeat
  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      btn_status2_o <= 7'h00;
      up_status_o   <= 1'b0;
      down_status_o <= 1'b0;
      tap_status_o  <= 1'b0;
      hold_status_o <= 1'b0;
      end_rpt_r     <= 7'h00;
    end
    else
    begin
      btn_status2_o <= sep_mode ? (btn_status2_o | grp_touch_en) & ~grp_rel_en | grp_touch_en : 7'h00;
      down_status_o <= sep_mode && (grp_touch_en[0] || grp_held_en[0]);
      up_status_o   <= sep_mode && (grp_touch_en[6] || grp_held_en[6]);
      tap_status_o  <= sep_mode && (grp_touch_en[0] || grp_touch_en[6]);
      hold_status_o <= sep_mode && (grp_held_en[0] || grp_held_en[6]);
      end_rpt_r     <= sep_mode ? (grp_held_en & 7'h41) : 7'h00;
    end
  end

  // slider interrupt engine: repeat counted in polling cycles, extra burst after fast slide
  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      state_r      <= ST_IDLE;
      extra_left_r <= 3'h0;
      rpt_cnt_r    <= 3'h0;
      rpt_sel_r    <= 3'h1;
      slider_int_o <= 1'b0;
    end
    else
    begin
      slider_int_o <= 1'b0;
      if (win_done)
        rpt_sel_r <= repeat_cycles(speed_cnt, speed_cfg_r[1:0], slide_base_rate_i);
      // press and end sensor hold repeats; release only when not suppressed
      if (|grp_touch_en)
        slider_int_o <= 1'b1;
      else if (|grp_rel_en && !cfg2_r[`TSGC_CFG_REL_SUPP] && (!sep_mode || |(grp_rel_en & 7'h3e)))
        slider_int_o <= 1'b1;
      case (state_r)
        ST_IDLE:
        begin
          if (!sep_mode && slide_done_i && speed_cfg_r[`TSGC_SPD_ACC_EN]
              && slide_cycles_i <= stime_cyc && extra_n != 3'h0)
          begin
            extra_left_r <= extra_n;
            state_r      <= ST_EXTRA;
          end
          else if (|rpt_held && poll_tick_i)
          begin
            rpt_cnt_r <= 3'h1;
            state_r   <= ST_RPT;
          end
        end
        ST_EXTRA:
        begin
          if (poll_tick_i)
          begin
            slider_int_o <= 1'b1;
            extra_left_r <= extra_left_r - 3'h1;
            if (extra_left_r == 3'h1)
              state_r <= ST_IDLE;
          end
        end
        ST_RPT:
        begin
          if (!(|rpt_held))
            state_r <= ST_IDLE;
          else if (poll_tick_i)
          begin
            if (rpt_cnt_r >= (sep_mode ? slide_base_rate_i : rpt_sel_r))
            begin
              slider_int_o <= 1'b1;
              rpt_cnt_r    <= 3'h1;
            end
            else
              rpt_cnt_r <= rpt_cnt_r + 3'h1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule // tsgc_top

// ### bench/tsgc_top_sva.sv
// concurrent checks on the slider group control ports
`timescale 1ns/10ps
module tsgc_top_sva
(
  // clock and reset
  input  wire        core_clk_i,
  input  wire        rst_i,
  // register writes
  input  wire        reg_wr_i,
  input  wire [7:0]  reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  // recalibration and sensor enables
  input  wire [7:0]  recal_done_i,
  input  wire [7:0]  recal_req_o,
  input  wire [6:0]  grp_sample_en_o,
  // noise
  input  wire [13:0] rf_noise_i,
  input  wire [13:0] lf_noise_i,
  input  wire [13:0] noise_flag_o,
  input  wire [13:0] delta_zero_o,
  // led and mode controls
  input  wire        polarity_wr_i,
  input  wire [10:0] polarity_val_i,
  input  wire [10:0] mirror_o,
  input  wire        link_invert_o,
  input  wire        link_min_eq_max_o,
  input  wire        led_eleven_freq_select_freq_o,
  input  wire        slider_mode_o,
  input  wire [6:0]  queue_repeat_sel_o
);
  reg  [7:0] cfg_r;
  wire       rf_only = cfg_r[3];
  wire       rf_fdis = cfg_r[2];

  // shadow of feature configuration two; reserved bit stays zero
  always @(posedge core_clk_i)
    if (rst_i)
      cfg_r <= 8'h00;
    else if (reg_wr_i && reg_addr_i == 8'h40)
      cfg_r <= reg_wdata_i & 8'hbf;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_recal_set:
    assert property (reg_wr_i && reg_addr_i == 8'h3f |=> (recal_req_o & $past(reg_wdata_i)) == $past(reg_wdata_i))
    else $error("recal request not set by write");
  a_recal_clear:
    assert property (!(reg_wr_i && reg_addr_i == 8'h3f) |=> (recal_req_o & $past(recal_done_i)) == 8'h00)
    else $error("recal request not cleared on done");
  a_link_invert:
    assert property (link_invert_o == cfg_r[7] && link_min_eq_max_o == !cfg_r[7])
    else $error("linked transition controls wrong");
  a_led11_select:
    assert property (led_eleven_freq_select_freq_o == cfg_r[5])
    else $error("led eleven frequency select wrong");
  a_group_mode:
    assert property (slider_mode_o == !cfg_r[1] && queue_repeat_sel_o == (cfg_r[1] ? 7'h3e : 7'h00))
    else $error("grouped mode steering wrong");
  a_mirror_follow:
    assert property (polarity_wr_i && !cfg_r[4] |=> mirror_o == $past(polarity_val_i))
    else $error("mirror did not follow polarity");
  a_mirror_hold:
    assert property (polarity_wr_i && cfg_r[4] |=> $stable(mirror_o))
    else $error("mirror changed while decoupled");
  a_noise_report:
    assert property (1'h1 |=> noise_flag_o == ($past(rf_noise_i) | ($past(lf_noise_i) & {14{!$past(rf_only)}})))
    else $error("noise flags wrong");
  a_rf_block:
    assert property (1'h1 |=> delta_zero_o == ($past(rf_noise_i) & {14{!$past(rf_fdis)}}))
    else $error("rf delta blocking wrong");
  a_enable_write:
    assert property (reg_wr_i && reg_addr_i == 8'h41 |=> {1'h0, grp_sample_en_o} == ($past(reg_wdata_i) & 8'h7f))
    else $error("sensor enables not updated");
endmodule // tsgc_top_sva

bind tsgc_top tsgc_top_sva tsgc_top_sva_i (.*);

// ### bench/tsgc_host_model.sv
// host side model: register writes and reads over the device register port
`timescale 1ns/10ps
module tsgc_host_model
(
  // clock
  input  wire       core_clk_i,
  // register port toward the device
  output reg        reg_wr_o,
  output reg        reg_rd_o,
  output reg  [7:0] reg_addr_o,
  output reg  [7:0] reg_wdata_o,
  input  wire [7:0] reg_rdata_i
);
  // idle port at time zero
  initial
  begin
    reg_wr_o    = 1'h0;
    reg_rd_o    = 1'h0;
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
  end

  // one write, taken on the edge after launch
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(posedge core_clk_i);
    reg_wr_o    <= 1'h1;
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    @(posedge core_clk_i);
    reg_wr_o    <= 1'h0;
    reg_wdata_o <= ~d; // stale data must not pass for valid
  end
  endtask

  // one read, data settles after the taking edge
  task rd(input [7:0] a, output [7:0] d);
  begin
    @(posedge core_clk_i);
    reg_rd_o   <= 1'h1;
    reg_addr_o <= a;
    @(posedge core_clk_i);
    reg_rd_o   <= 1'h0;
    #1;
    d = reg_rdata_i;
  end
  endtask
endmodule // tsgc_host_model

// ### bench/tsgc_top_tb.sv
// self-checking bench for the slider group control block
`timescale 1ns/10ps
module tsgc_top_tb;
  reg         core_clk_i, rst_i, poll_tick_i, slide_done_i, polarity_wr_i, bg_on;
  reg  [6:0]  grp_touch_i, grp_release_i, grp_held_i;
  reg  [5:0]  slide_cycles_i;
  reg  [2:0]  slide_base_rate_i;
  reg  [7:0]  recal_done_i, d, q, cfg, rq;
  reg  [13:0] rf_noise_i, lf_noise_i;
  reg  [10:0] polarity_val_i, mir;
  reg  [39:0] rst_addr = 40'h3e3f404155;
  reg  [39:0] rst_val  = 40'hc500007f00;
  wire        reg_wr_i, reg_rd_i, link_invert_o, link_min_eq_max_o, led_eleven_freq_select_freq_o, slider_int_o;
  wire        up_status_o, down_status_o, tap_status_o, hold_status_o, slider_mode_o;
  wire [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, recal_req_o;
  wire [6:0]  grp_sample_en_o, btn_status2_o, queue_repeat_sel_o;
  wire [13:0] noise_flag_o, delta_zero_o;
  wire [10:0] mirror_o;
  wire [11:0] ev_got = {slider_int_o, up_status_o, down_status_o, tap_status_o, hold_status_o, btn_status2_o};
  integer     error_cnt = 0;
  integer     tests_run = 0;
  integer     i;
  integer     n, b;
  reg  [6:0]  t_v, r_v, h_v;
  reg  [7:0]  s;

  tsgc_top tsgc_top_i (.*);
  tsgc_host_model tsgc_host_model_i (.core_clk_i(core_clk_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
    .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o));

  // 40 MHz clock
  initial
  begin
    core_clk_i = 1'h0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  // noise flags expected from both sources and the rf-only setting
  function [13:0] nz_exp(input [13:0] rf, input [13:0] lf, input only);
    nz_exp = rf | (lf & {14{~only}});
  endfunction

  // extra slide interrupts: none past the limit or when disabled, else a fraction of the cap
  function [2:0] extra_exp(input [7:0] sc, input [5:0] t);
    integer lim;
    begin
      lim = (350 + 210 * sc[3:2]) / 35;
      if (!sc[7] || t > lim)
        extra_exp = 3'h0;
      else if (2 * t < lim)
        extra_exp = sc[6:4];
      else if (4 * t < 3 * lim)
        extra_exp = sc[6:4] >> 1;
      else
        extra_exp = sc[6:4] >> 2;
    end
  endfunction

  // event outputs {interrupt, up, down, tap, hold, touched status bits}; m is {separate, no release}
  function [11:0] ev_exp(input [1:0] m, input [6:0] en, input [6:0] t0, input [6:0] r0, input [6:0] h0);
    reg [6:0] t, r, h;
    begin
      t = t0 & en;
      r = r0 & en;
      h = h0 & en;
      ev_exp = {|t || (|r && !m[0] && (!m[1] || |(r & 7'h3e))), m[1] & (t[6] | h[6]), m[1] & (t[0] | h[0]),
                m[1] & (t[0] | t[6]), m[1] & (h[0] | h[6]), m[1] ? t : 7'h00};
    end
  endfunction

  // polling ticks every other cycle; counts the slider interrupts that follow them
  task tick_count(input integer cnt, output integer c);
  begin
    c = 0;
    repeat (cnt)
    begin
      @(posedge core_clk_i);
      poll_tick_i <= 1'h1;
      @(posedge core_clk_i);
      poll_tick_i <= 1'h0;
      #1;
      c = c + slider_int_o;
    end
  end
  endtask

  // one cycle of touch and release pulses, held level stays as given
  task grp_event(input [6:0] t, input [6:0] r, input [6:0] h);
  begin
    @(posedge core_clk_i);
    grp_touch_i   <= t;
    grp_release_i <= r;
    grp_held_i    <= h;
    @(posedge core_clk_i);
    grp_touch_i   <= 7'h00;
    grp_release_i <= 7'h00;
    #1;
  end
  endtask

  task chk(input [13:0] got, input [13:0] exp);
  begin
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask

  task final_report;
  begin
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask

  // random measurement traffic keeps the event logic busy meanwhile
  always @(posedge core_clk_i)
    if (bg_on)
    begin
      poll_tick_i       <= ($urandom % 4) == 0;
      grp_touch_i       <= 7'($urandom & $urandom);
      grp_release_i     <= 7'($urandom & $urandom);
      grp_held_i        <= 7'($urandom);
      slide_done_i      <= ($urandom % 8) == 0;
      slide_cycles_i    <= 6'($urandom);
      slide_base_rate_i <= 3'($urandom);
    end

  // hang guard, far beyond the thousand-odd cycles the tests need
  initial
  begin
    #(25 * 20000);
    error_cnt = error_cnt + 1;
    final_report;
  end

  initial
  begin
    {poll_tick_i, slide_done_i, polarity_wr_i, bg_on} = 4'h0;
    {grp_touch_i, grp_release_i, grp_held_i, slide_cycles_i, slide_base_rate_i} = 30'h0;
    {recal_done_i, rf_noise_i, lf_noise_i, polarity_val_i, mir} = 58'h0;
    rst_i = 1'h1;
    void'($urandom(83791));
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'h0;
    bg_on <= 1'h1;
    // reset values, then an unmapped place that reads zero
    for (i = 0; i < 5; i = i + 1)
    begin
      tsgc_host_model_i.rd(rst_addr[8*i +: 8], q);
      chk(q, rst_val[8*i +: 8]);
    end
    tsgc_host_model_i.wr(8'h55, 8'hff);
    tsgc_host_model_i.rd(8'h55, q);
    chk(q, 8'h00);
    // group bit and sensor one requested together, sensor one cleared first, then random done and request bytes
    rq = 8'h81;
    tsgc_host_model_i.wr(8'h3f, rq);
    for (i = 0; i < 8; i = i + 1)
    begin
      #1;
      chk(recal_req_o, rq);
      d = (i == 0) ? 8'h01 : 8'($urandom);
      @(posedge core_clk_i);
      recal_done_i <= d;
      @(posedge core_clk_i);
      recal_done_i <= 8'h00;
      rq = rq & ~d;
      #1;
      chk(recal_req_o, rq);
      tsgc_host_model_i.rd(8'h3f, q);
      chk(q, rq);
      d = 8'($urandom);
      rq = rq | d;
      tsgc_host_model_i.wr(8'h3f, d);
    end
    // feature configuration: all zero, all one, then random
    for (i = 0; i < 12; i = i + 1)
    begin
      cfg = (i < 2) ? {8{i[0]}} : 8'($urandom);
      tsgc_host_model_i.wr(8'h40, cfg);
      tsgc_host_model_i.rd(8'h40, q);
      chk(q, cfg & 8'hbf);
      chk({link_invert_o, link_min_eq_max_o, led_eleven_freq_select_freq_o}, {cfg[7], ~cfg[7], cfg[5]});
      chk({slider_mode_o, queue_repeat_sel_o}, {~cfg[1], cfg[1] ? 7'h3e : 7'h00});
      @(posedge core_clk_i);
      rf_noise_i     <= 14'($urandom);
      lf_noise_i     <= 14'($urandom);
      polarity_wr_i  <= 1'h1;
      polarity_val_i <= 11'($urandom);
      @(posedge core_clk_i);
      polarity_wr_i  <= 1'h0;
      if (!cfg[4])
        mir = polarity_val_i;
      #1;
      chk(noise_flag_o, nz_exp(rf_noise_i, lf_noise_i, cfg[3]));
      chk(delta_zero_o, cfg[2] ? 14'h0 : rf_noise_i);
      chk(mirror_o, mir);
    end
    // sensor enables and speed settings accept updates at any time
    for (i = 0; i < 6; i = i + 1)
    begin
      d = (i == 0) ? 8'hff : 8'($urandom);
      tsgc_host_model_i.wr(8'h41, d);
      #1;
      chk(grp_sample_en_o, d[6:0]);
      tsgc_host_model_i.rd(8'h41, q);
      chk(q, d & 8'h7f);
      tsgc_host_model_i.wr(8'h3e, d);
      tsgc_host_model_i.rd(8'h3e, q);
      chk(q, d);
    end
    tsgc_host_model_i.wr(8'h41, 8'h7f);
    // quiet the random traffic; a cycle apart so the two drivers never meet
    @(posedge core_clk_i);
    bg_on <= 1'h0;
    @(posedge core_clk_i);
    {poll_tick_i, slide_done_i} <= 2'h0;
    {grp_touch_i, grp_release_i, grp_held_i} <= 21'h0;
    // press, release and hold in both grouped modes: end touch, end release, end hold first
    for (i = 0; i < 24; i = i + 1)
    begin
      cfg = (i < 3) ? 8'h02 : {6'h00, 2'($urandom)};
      d   = (i < 3) ? 8'h7f : 8'($urandom);
      t_v = (i == 0) ? 7'h01 : (i == 2) ? 7'h40 : (i == 1) ? 7'h00 : 7'($urandom & $urandom);
      r_v = (i == 1) ? 7'h41 : (i < 3) ? 7'h00 : 7'($urandom & $urandom);
      h_v = (i == 2) ? 7'h01 : (i < 3) ? 7'h00 : 7'($urandom & $urandom);
      tsgc_host_model_i.wr(8'h40, cfg);
      tsgc_host_model_i.wr(8'h41, d);
      grp_event(t_v, r_v, h_v);
      chk(ev_got & {5'h1f, t_v & d[6:0]}, ev_exp(cfg[1:0], d[6:0], t_v, r_v, h_v));
    end
    tsgc_host_model_i.wr(8'h41, 8'h7f);
    tsgc_host_model_i.wr(8'h40, 8'h00);
    @(posedge core_clk_i);
    grp_held_i <= 7'h00;
    // extra interrupts after a slide: default, disabled, just past and at the limit, then random
    for (i = 0; i < 12; i = i + 1)
    begin
      s = (i == 0) ? 8'hc5 : (i == 1) ? 8'h45 : (i < 4) ? 8'hf0 : 8'($urandom);
      b = (i < 2) ? 0 : (i == 2) ? 11 : (i == 3) ? 10 : $urandom % 32;
      tsgc_host_model_i.wr(8'h3e, s);
      tick_count(8, n);
      @(posedge core_clk_i);
      slide_done_i   <= 1'h1;
      slide_cycles_i <= 6'(b);
      @(posedge core_clk_i);
      slide_done_i   <= 1'h0;
      tick_count(9, n);
      chk(14'(n), extra_exp(s, 6'(b)));
    end
    // held slider, then held end sensor: one interrupt per normal rate in polling cycles
    for (i = 0; i < 4; i = i + 1)
    begin
      b = 1 + $urandom % 7;
      tsgc_host_model_i.wr(8'h40, {6'h00, i[0], 1'h0});
      @(posedge core_clk_i);
      slide_base_rate_i <= 3'(b);
      grp_held_i        <= i[0] ? 7'h40 : 7'h08;
      tick_count(12, n);
      tick_count(4 * b, n);
      chk(14'(n), 14'h0004);
      @(posedge core_clk_i);
      grp_held_i <= 7'h00;
    end
    final_report;
  end
endmodule // tsgc_top_tb
